// *** usbd_ctl.sv ***
// Purpose: Buffer-ready, test mode, error count, PHY access and DMA control registers.
// Assumes: APB slave on pclk; link pins sampled through two flops.
// Notes: Answers every transfer with no wait state.
// Notes on behaviour
// - Buffer-0 ready bits, ep7 bit24..ep0 bit31.
// - Unready buffer answers tokens with NAK.
// - Test field bits 29-31 selects operation.
// - J or K chirp held until reset.
// - NAK mode: NAK good-crc IN tokens only.
// - Packet mode repeats test packet until reset.
// - Three read-only 8-bit error counters.
// - Bus reset or read clears counters.
// - Stuff error counts and flags.
// - Bad PID check counts and flags.
// - CRC mismatch counts and flags.
// - Counters wrap past 255.
// - Without error logic counters read zero.
// - PHY read: busy, fetch byte, done flag.
// - PHY write: busy until written, done flag.
// - Access register field layout.
// - Access only while link is idle.
// - Writes while busy are ignored.
// - Access needs engine enable set.
// - Soft reset key; other values error.
// - DMA control bit 0 is direction.
// - Bit 1 lets DMA copy ready bits.
// - Bits 16-22 are buffer-1 ready requests.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
module usbd_ctl import usbd_pkg::*; #(
  parameter int ERROR_LOGIC_PRESENT = 1
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events from the serial engine.
  input wire logic link_busy,
  input wire logic usb_reset_det,
  input wire logic stuff_err_evt,
  input wire logic pid_evt,
  input wire logic [7:0] pid_byte,
  input wire logic crc_evt,
  input wire logic crc_good,
  input wire logic tok_evt,
  input wire logic tok_in,
  input wire logic tok_crc_ok,
  input wire logic [2:0] tok_ep,
  input wire logic dma_done,
  // Controls and flags to the engine and DMA.
  output logic [15:0] buf_ready,
  output logic chirp_j,
  output logic chirp_k,
  output logic test_packet,
  output logic send_nak,
  output logic stuffing_error_flag,
  output logic packet_id_error_flag,
  output logic checksum_error_flag,
  output logic phy_access_done_flag,
  output logic dma_dir,
  output logic dma_reset,
  // Link pins.
  input wire logic ulpi_clk,
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  input wire logic [7:0] ulpi_data_in,
  output logic [7:0] ulpi_data_out,
  output logic ulpi_data_oe,
  output logic ulpi_stp
);
  if (ERROR_LOGIC_PRESENT < 0 || ERROR_LOGIC_PRESENT > 1) begin : g_chk
    $error("ERROR_LOGIC_PRESENT must be 0 or 1");
  end

  // Register state.
  logic [31:0] brr_q;
  logic [2:0] tm_q;
  logic busy_q;
  logic [7:0] dat_q;
  logic wsel_q;
  logic [5:0] idx_q;
  logic eng_en_q;
  logic dir_q;
  logic src_q;
  logic [6:0] d1rdy_q;
  // Bus answer and output state.
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic j_q;
  logic k_q;
  logic pkt_q;
  logic nak_q;
  logic [2:0] flag_q;
  logic done_q;
  logic dmarst_q;
  // Link sequencer state.
  usbd_ph_e ph_q;
  logic [7:0] dout_q;
  logic oe_q;
  logic stp_q;
  logic [7:0] rdat_q;
  logic ck_d_q;

  // Bus phase decode.
  wire setup_w = psel & ~penable;
  wire acc_w = psel & penable & pready_q;
  wire wr_w = acc_w & pwrite;
  wire rd_setup_w = setup_w & ~pwrite;

  // Address decode.
  wire hit_brr_w = paddr == EPRDY_OFF;
  wire hit_tm_w = paddr == TSEL_OFF;
  wire hit_ec_w = paddr == ERRC_OFF;
  wire hit_pa_w = paddr == PHYA_OFF;
  wire hit_en_w = paddr == ECTL_OFF;
  wire hit_dsr_w = paddr == DSR_OFF;
  wire hit_dc_w = paddr == DCTL_OFF;
  wire mapped_w = hit_brr_w | hit_tm_w | hit_ec_w | hit_pa_w | hit_en_w | hit_dsr_w | hit_dc_w;
  // A soft reset write must carry the key word.
  wire key_ok_w = pwdata == DSR_KEY;
  wire err_w = ~mapped_w | (hit_dsr_w & pwrite & ~key_ok_w);

  // Counter plumbing.
  usbd_cnt_if cif[3] ();
  wire pid_bad_w = pid_evt & (pid_byte[7:4] != ~pid_byte[3:0]);
  wire crc_bad_w = crc_evt & ~crc_good;
  wire [2:0] inc_w = {crc_bad_w, pid_bad_w, stuff_err_evt};
  wire ec_clr_w = usb_reset_det | (rd_setup_w & hit_ec_w);

  // One counter per error kind, or none without error logic.
  for (genvar i = 0; i < 3; i++) begin : g_cnt
    assign cif[i].inc = inc_w[i];
    assign cif[i].clr = ec_clr_w;
    if (ERROR_LOGIC_PRESENT == 1) begin : g_on
      usbd_errcnt u_cnt (
        .clk(pclk),
        .rst_n(presetn),
        .c(cif[i].cnt_side)
      );
    end else begin : g_off
      assign cif[i].cnt = '0;
    end
  end

  // Read views of each register.
  wire [31:0] ec_w = {8'h00, cif[2].cnt, cif[1].cnt, cif[0].cnt};
  wire [31:0] tm_w = {tm_q, 29'h0};
  wire [31:0] pa_w = {idx_q, wsel_q, 1'b0, dat_q, 15'h0, busy_q};
  wire [31:0] en_w = {31'h0, eng_en_q};
  wire [31:0] dc_w = {9'h0, d1rdy_q, 14'h0, src_q, dir_q};
  wire [31:0] rdata_w = hit_brr_w ? brr_q :
                        hit_tm_w ? tm_w :
                        hit_ec_w ? ec_w :
                        hit_pa_w ? pa_w :
                        hit_en_w ? en_w :
                        hit_dc_w ? dc_w : REG_RST;

  // Test selection decode; only values 1 to 4 count as active.
  wire tm_act_w = (tm_q != TM_NORM) && (tm_q <= TM_PKT);
  wire tm_wr_w = wr_w & hit_tm_w & ~tm_act_w;

  // Buffer-0 ready bit of the addressed endpoint; ep0 sits highest.
  wire [7:0] b0_w = brr_q[BUF0_LSB +: 8];
  wire ep_rdy_w = b0_w[3'd7 - tok_ep];
  wire nak_d = tok_evt & tok_crc_ok &
               ((tm_q == TM_NAK) ? tok_in : (~tm_act_w & ~ep_rdy_w));

  // Hardware copy of buffer-1 requests after a good DMA transfer.
  wire [31:0] hw_set_w = (dma_done & src_q) ? {9'h0, d1rdy_q, 16'h0} : REG_RST;
  wire [31:0] brr_d = ((wr_w & hit_brr_w) ? (pwdata & EPRDY_MASK) : brr_q) | hw_set_w;

  // Access register writes are taken only while idle.
  wire pa_wr_w = wr_w & hit_pa_w & ~busy_q;

  // Bus answer: data and error are ready for the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= REG_RST;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup_w;
      prdata_q <= rd_setup_w ? rdata_w : REG_RST;
      pslverr_q <= setup_w & err_w;
    end
  end

  // Buffer-ready and test selection registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brr_q <= REG_RST;
      tm_q <= TM_NORM;
    end else begin
      brr_q <= brr_d;
      if (tm_wr_w) begin
        tm_q <= pwdata[TM_LSB +: 3];
      end
    end
  end

  // Engine enable and DMA control registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_en_q <= 1'b0;
      dir_q <= 1'b0;
      src_q <= 1'b0;
      d1rdy_q <= '0;
    end else begin
      if (wr_w & hit_en_w) begin
        eng_en_q <= pwdata[EC_EN];
      end
      if (wr_w & hit_dc_w) begin
        dir_q <= pwdata[DC_DIR];
        src_q <= pwdata[DC_SRC];
        d1rdy_q <= pwdata[BUF1_LSB +: 7];
      end
    end
  end

  // Access register; completion clears busy and returns read data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      dat_q <= '0;
      wsel_q <= 1'b0;
      idx_q <= '0;
    end else if (pa_wr_w) begin
      busy_q <= 1'b1;
      dat_q <= pwdata[PA_DAT_LSB +: 8];
      wsel_q <= pwdata[PA_WSEL];
      idx_q <= pwdata[PA_IDX_LSB +: 6];
    end else if (done_q) begin
      busy_q <= 1'b0;
      if (!wsel_q) begin
        dat_q <= rdat_q;
      end
    end
  end

  // Engine-facing outputs and event flags, one cycle behind their cause.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      j_q <= 1'b0;
      k_q <= 1'b0;
      pkt_q <= 1'b0;
      nak_q <= 1'b0;
      flag_q <= '0;
      dmarst_q <= 1'b0;
    end else begin
      j_q <= tm_q == TM_J;
      k_q <= tm_q == TM_K;
      pkt_q <= tm_q == TM_PKT;
      nak_q <= nak_d;
      flag_q <= (ERROR_LOGIC_PRESENT == 1) ? inc_w : 3'h0;
      dmarst_q <= wr_w & hit_dsr_w & key_ok_w;
    end
  end

  // Link pins pass two flops before use.
  logic [10:0] ls_q;
  usbd_sync #(.W(11)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({ulpi_clk, ulpi_dir, ulpi_nxt, ulpi_data_in}),
    .s_q(ls_q)
  );
  wire lck_s = ls_q[10];
  wire dir_s = ls_q[9];
  wire nxt_s = ls_q[8];
  wire [7:0] din_s = ls_q[7:0];
  wire rise_w = lck_s & ~ck_d_q;
  // Start only when enabled and nothing else uses the link.
  wire go_w = busy_q & eng_en_q & ~dir_s & ~link_busy;

  // Link register access sequencer, stepped on link clock rises.
  // A turnaround from the PHY during the command aborts and retries later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= PH_IDLE;
      dout_q <= '0;
      oe_q <= 1'b0;
      stp_q <= 1'b0;
      rdat_q <= '0;
      done_q <= 1'b0;
      ck_d_q <= 1'b0;
    end else begin
      ck_d_q <= lck_s;
      done_q <= 1'b0;
      if (rise_w) begin
        unique case (ph_q)
          PH_IDLE: if (go_w) begin
            dout_q <= {wsel_q ? TXC_WR : TXC_RD, idx_q};
            oe_q <= 1'b1;
            ph_q <= PH_CMD;
          end
          PH_CMD: if (dir_s) begin
            oe_q <= 1'b0;
            ph_q <= PH_IDLE;
          end else if (nxt_s && wsel_q) begin
            dout_q <= dat_q;
            ph_q <= PH_WDAT;
          end else if (nxt_s) begin
            oe_q <= 1'b0;
            ph_q <= PH_TURN;
          end
          PH_WDAT: if (nxt_s) begin
            stp_q <= 1'b1;
            dout_q <= '0;
            ph_q <= PH_STP;
          end
          PH_STP: begin
            stp_q <= 1'b0;
            oe_q <= 1'b0;
            ph_q <= PH_DONE;
          end
          PH_TURN: if (dir_s) begin
            ph_q <= PH_RDAT;
          end
          PH_RDAT: begin
            rdat_q <= din_s;
            ph_q <= PH_DONE;
          end
          PH_DONE: begin
            done_q <= 1'b1;
            ph_q <= PH_IDLE;
          end
          default: ph_q <= PH_IDLE;
        endcase
      end
    end
  end

  // Ports come straight from flops.
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign buf_ready = brr_q[31:16];
  assign chirp_j = j_q;
  assign chirp_k = k_q;
  assign test_packet = pkt_q;
  assign send_nak = nak_q;
  assign stuffing_error_flag = flag_q[0];
  assign packet_id_error_flag = flag_q[1];
  assign checksum_error_flag = flag_q[2];
  assign phy_access_done_flag = done_q;
  assign dma_dir = dir_q;
  assign dma_reset = dmarst_q;
  assign ulpi_data_out = dout_q;
  assign ulpi_data_oe = oe_q;
  assign ulpi_stp = stp_q;

  tm_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    tm_act_w |=> tm_q == $past(tm_q)) else $error("test mode left without reset");
  nak_test_a: assert property (@(posedge pclk) disable iff (!presetn)
    tok_evt && tok_in && tok_crc_ok && tm_q == TM_NAK |=> send_nak) else $error("missing test NAK");
  nak_crc_a: assert property (@(posedge pclk) disable iff (!presetn)
    tok_evt && !tok_crc_ok |=> !send_nak) else $error("NAK on bad crc5");
  nak_unready_a: assert property (@(posedge pclk) disable iff (!presetn)
    tok_evt && tok_crc_ok && tm_q == TM_NORM && !ep_rdy_w |=> send_nak) else $error("missing NAK");
  busy_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_w && hit_pa_w && busy_q |=> $stable(idx_q) && $stable(wsel_q)) else $error("write taken while busy");
  phy_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    ph_q == PH_IDLE && (dir_s || link_busy || !eng_en_q) |=> ph_q == PH_IDLE) else $error("access on busy link");
  key_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_w && pwrite && hit_dsr_w && !key_ok_w |=> pslverr && !dma_reset ##1 !dma_reset)
    else $error("bad key not refused");
  dma_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    dma_done && src_q |=> (brr_q[22:16] & $past(d1rdy_q)) == $past(d1rdy_q)) else $error("ready copy lost");
  pid_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    pid_bad_w && ERROR_LOGIC_PRESENT == 1 |=> packet_id_error_flag) else $error("PID error not flagged");
  done_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    done_q |=> !busy_q && phy_access_done_flag == 1'b0) else $error("busy not cleared");
endmodule

// *** usbd_pkg.sv ***
// Purpose: Shared constants for the device control and status block.
// Assumes: 32-bit APB data, byte addresses on paddr.
// Notes: Field positions count from bit 0 as the least significant bit.
package usbd_pkg;
  // Register byte offsets.
  localparam logic [11:0] EPRDY_OFF = 12'h114;
  localparam logic [11:0] TSEL_OFF = 12'h118;
  localparam logic [11:0] ERRC_OFF = 12'h11C;
  localparam logic [11:0] PHYA_OFF = 12'h120;
  localparam logic [11:0] ECTL_OFF = 12'h124;
  localparam logic [11:0] DSR_OFF = 12'h200;
  localparam logic [11:0] DCTL_OFF = 12'h204;
  // Field positions.
  localparam int BUF1_LSB = 16;
  localparam int BUF0_LSB = 24;
  localparam int TM_LSB = 29;
  localparam int PA_DAT_LSB = 16;
  localparam int PA_WSEL = 25;
  localparam int PA_IDX_LSB = 26;
  localparam int DC_DIR = 0;
  localparam int DC_SRC = 1;
  localparam int EC_EN = 0;
  // Widths, reset values and keys.
  localparam int ERR_CNT_W = 8;
  localparam logic [31:0] REG_RST = 32'h00000000;
  localparam logic [31:0] EPRDY_MASK = 32'hFF7F0000;
  localparam logic [31:0] DSR_KEY = 32'h0000000A;
  // Compliance test selections.
  localparam logic [2:0] TM_NORM = 3'h0;
  localparam logic [2:0] TM_J = 3'h1;
  localparam logic [2:0] TM_K = 3'h2;
  localparam logic [2:0] TM_NAK = 3'h3;
  localparam logic [2:0] TM_PKT = 3'h4;
  // Link command prefixes for register write and read.
  localparam logic [1:0] TXC_WR = 2'h2;
  localparam logic [1:0] TXC_RD = 2'h3;
  // Link register access sequencer.
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_CMD = 3'b001,
    PH_WDAT = 3'b010,
    PH_STP = 3'b011,
    PH_TURN = 3'b100,
    PH_RDAT = 3'b101,
    PH_DONE = 3'b110
  } usbd_ph_e;
endpackage

// *** usbd_cnt_if.sv ***
// Purpose: Event and clear lines to one error counter, count back.
// Assumes: Same clock on both sides.
// Notes: None.
`timescale 1ns/10ps
interface usbd_cnt_if;
  import usbd_pkg::*;
  logic inc;
  logic clr;
  logic [ERR_CNT_W-1:0] cnt;
  modport cnt_side (input inc, input clr, output cnt);
  modport ctl_side (output inc, output clr, input cnt);
endinterface

// *** usbd_sync.sv ***
// Purpose: Two-flop synchroniser for levels from outside the clock domain.
// Assumes: Inputs are levels or slow relative to clk.
// Notes: The first stage feeds only the second.
`timescale 1ns/10ps
module usbd_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Levels in and out.
  input wire logic [W-1:0] d,
  output logic [W-1:0] s_q
);
  logic [W-1:0] m_q;

  // Two stages to settle metastability.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m_q <= '0;
      s_q <= '0;
    end else begin
      m_q <= d;
      s_q <= m_q;
    end
  end
endmodule

// *** usbd_errcnt.sv ***
// Purpose: One wrapping error counter with clear.
// Assumes: inc and clr come from logic on the same clock.
// Notes: An event in the clearing cycle is kept as a count of one.
`timescale 1ns/10ps
module usbd_errcnt import usbd_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Counter lines.
  usbd_cnt_if.cnt_side c
);
  logic [ERR_CNT_W-1:0] cnt_q;

  // Clear has priority over counting but never loses the event.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (c.clr) begin
      cnt_q <= {{(ERR_CNT_W-1){1'b0}}, c.inc};
    end else if (c.inc) begin
      cnt_q <= cnt_q + ERR_CNT_W'(1);
    end
  end

  assign c.cnt = cnt_q;

  wrap_cnt_a: assert property (@(posedge clk) disable iff (!rst_n)
    c.inc && !c.clr && (&cnt_q) |=> cnt_q == '0) else $error("counter did not wrap");
  clear_cnt_a: assert property (@(posedge clk) disable iff (!rst_n)
    c.clr |=> cnt_q == {{(ERR_CNT_W-1){1'b0}}, $past(c.inc)}) else $error("counter not cleared");
endmodule

// *** usbd_phy_model.sv ***
// Purpose: Link-side transceiver model with a small register file.
// Assumes: Register writes use the command, data and stop sequence; reads use command, turnaround and data.
// Notes: The clock runs free, since the block needs link rises to start a command.
`timescale 1ns/10ps
module usbd_phy_model (
  // Link pins.
  output logic ulpi_clk,
  output logic ulpi_dir,
  output logic ulpi_nxt,
  output logic [7:0] ulpi_data_in,
  input wire logic [7:0] ulpi_data_out,
  input wire logic ulpi_data_oe
);
  logic [7:0] regs [64];
  logic [5:0] idx;
  logic [2:0] st;
  initial begin
    ulpi_clk = 1'b0;
    ulpi_dir = 1'b0;
    ulpi_nxt = 1'b0;
    ulpi_data_in = 8'h00;
    idx = 6'h00;
    st = 3'h0;
    foreach (regs[i]) regs[i] = 8'h00;
  end
  // Link clock of 125 ns period.
  always #62.5 ulpi_clk = ~ulpi_clk;
  // Outputs move on the falling edge, so they are settled well before the next rise.
  // An undriven bus shows a pattern that toggles every cycle.
  always @(negedge ulpi_clk) begin
    case (st)
      3'h0: begin
        ulpi_data_in <= ~ulpi_data_in;
        if (ulpi_data_oe && ulpi_data_out[7]) begin
          ulpi_nxt <= 1'b1;
          idx <= ulpi_data_out[5:0];
          st <= ulpi_data_out[6] ? 3'h3 : 3'h1;
        end
      end
      3'h1: begin
        regs[idx] <= ulpi_data_out;
        st <= 3'h2;
      end
      3'h2: begin
        ulpi_nxt <= 1'b0;
        st <= 3'h0;
      end
      3'h3: begin
        ulpi_nxt <= 1'b0;
        ulpi_dir <= 1'b1;
        st <= 3'h4;
      end
      3'h4: begin
        ulpi_data_in <= regs[idx];
        st <= 3'h5;
      end
      default: begin
        ulpi_dir <= 1'b0;
        ulpi_data_in <= ~regs[idx];
        st <= 3'h0;
      end
    endcase
  end
endmodule

// *** usbd_ctl_tb.sv ***
// Purpose: Self-checking bench for the control and status block.
// Assumes: Slave answers with no wait state; link model on the far side.
// Notes: A second build without error logic shares the bus and the events, so its zero reads can be judged.
`timescale 1ns/10ps
module usbd_ctl_tb;
  import usbd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic link_busy, usb_reset_det, stuff_err_evt, pid_evt, crc_evt, crc_good, tok_evt, tok_in, tok_crc_ok, dma_done;
  logic [7:0] pid_byte, ulpi_data_in, ulpi_data_out;
  logic [2:0] tok_ep;
  logic [15:0] buf_ready;
  logic chirp_j, chirp_k, test_packet, send_nak, stuffing_error_flag, packet_id_error_flag, checksum_error_flag;
  logic phy_access_done_flag, dma_dir, dma_reset, ulpi_clk, ulpi_dir, ulpi_nxt, ulpi_data_oe, ulpi_stp;
  int n_fail = 0;
  int check_count = 0;
  int rst_seen = 0;
  int stp_seen = 0;
  logic stp_prev = 1'b0;
  logic bare_flag;
  logic [31:0] bare_rdata, bare_r;
  usbd_ctl uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_busy(link_busy),
    .usb_reset_det(usb_reset_det), .stuff_err_evt(stuff_err_evt), .pid_evt(pid_evt), .pid_byte(pid_byte),
    .crc_evt(crc_evt), .crc_good(crc_good), .tok_evt(tok_evt), .tok_in(tok_in), .tok_crc_ok(tok_crc_ok),
    .tok_ep(tok_ep), .dma_done(dma_done), .buf_ready(buf_ready), .chirp_j(chirp_j), .chirp_k(chirp_k),
    .test_packet(test_packet), .send_nak(send_nak), .stuffing_error_flag(stuffing_error_flag),
    .packet_id_error_flag(packet_id_error_flag), .checksum_error_flag(checksum_error_flag),
    .phy_access_done_flag(phy_access_done_flag), .dma_dir(dma_dir), .dma_reset(dma_reset),
    .ulpi_clk(ulpi_clk), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_data_in(ulpi_data_in),
    .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe), .ulpi_stp(ulpi_stp));
  usbd_phy_model u_phy (.ulpi_clk(ulpi_clk), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
    .ulpi_data_in(ulpi_data_in), .ulpi_data_out(ulpi_data_out), .ulpi_data_oe(ulpi_data_oe));
  // Build without counters; it follows the same link answers but never drives the link.
  usbd_ctl #(.ERROR_LOGIC_PRESENT(0)) uut_bare (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(bare_rdata), .pready(), .pslverr(),
    .link_busy(link_busy), .usb_reset_det(usb_reset_det), .stuff_err_evt(stuff_err_evt), .pid_evt(pid_evt),
    .pid_byte(pid_byte), .crc_evt(crc_evt), .crc_good(crc_good), .tok_evt(tok_evt), .tok_in(tok_in),
    .tok_crc_ok(tok_crc_ok), .tok_ep(tok_ep), .dma_done(dma_done), .buf_ready(), .chirp_j(), .chirp_k(),
    .test_packet(), .send_nak(), .stuffing_error_flag(bare_flag), .packet_id_error_flag(),
    .checksum_error_flag(), .phy_access_done_flag(), .dma_dir(), .dma_reset(), .ulpi_clk(ulpi_clk),
    .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt), .ulpi_data_in(ulpi_data_in), .ulpi_data_out(),
    .ulpi_data_oe(), .ulpi_stp());
  // System clock of 8 ns period.
  always #4 pclk = ~pclk;
  // Counts soft reset pulses, since their exact cycle is the design's choice.
  always @(posedge pclk) begin
    if (dma_reset === 1'b1) rst_seen++;
  end
  // Counts stop pulses on the link; only a register write ends with one.
  always @(posedge pclk) begin
    if (ulpi_stp === 1'b1 && stp_prev !== 1'b1) stp_seen++;
    stp_prev = ulpi_stp;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  // One transfer; waits for pready however long it takes, and only the watchdog ends a hang.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    bare_r = bare_rdata;
    chk(n, 1);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk(e, xe);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(r, x);
    chk(e, xe);
  endtask
  task automatic reset_dut;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // One-cycle event pulse; returns just after the edge that takes it.
  task automatic pulse(input int k);
    @(posedge pclk);
    case (k)
      0: stuff_err_evt <= 1'b1;
      1: pid_evt <= 1'b1;
      2: crc_evt <= 1'b1;
      3: tok_evt <= 1'b1;
      4: dma_done <= 1'b1;
      default: usb_reset_det <= 1'b1;
    endcase
    @(posedge pclk);
    {stuff_err_evt, pid_evt, crc_evt, tok_evt, dma_done, usb_reset_det} <= 6'h00;
    #1;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (phy_access_done_flag !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk(n < 3000, 1'b1);
  endtask
  task automatic t_regs;
    logic [11:0] offs [6] = '{EPRDY_OFF, TSEL_OFF, ERRC_OFF, PHYA_OFF, ECTL_OFF, DCTL_OFF};
    foreach (offs[i]) rd(offs[i], REG_RST, 1'b0);
    rd(12'h128, 32'h00000000, 1'b1);
    rd(DSR_OFF, 32'h00000000, 1'b0);
    $display("Test regs done");
  endtask
  task automatic t_ready;
    wr(EPRDY_OFF, 32'hFFFFFFFF, 1'b0);
    rd(EPRDY_OFF, EPRDY_MASK, 1'b0);
    chk(buf_ready, 16'hFF7F);
    wr(EPRDY_OFF, 32'h01000000, 1'b0);
    @(posedge pclk);
    tok_in <= 1'b1;
    tok_crc_ok <= 1'b1;
    for (int ep = 0; ep < 8; ep += 7) begin
      @(posedge pclk);
      tok_ep <= ep[2:0];
      pulse(3);
      chk(send_nak, ep == 0);
    end
    $display("Test ready done");
  endtask
  task automatic t_err;
    repeat (3) begin
      pulse(0);
      chk(stuffing_error_flag, 1'b1);
      chk(bare_flag, 1'b0);
    end
    @(posedge pclk);
    pid_byte <= 8'h00;
    pulse(1);
    chk(packet_id_error_flag, 1'b1);
    @(posedge pclk);
    pid_byte <= 8'h69;
    pulse(1);
    chk(packet_id_error_flag, 1'b0);
    @(posedge pclk);
    crc_good <= 1'b0;
    repeat (2) begin
      pulse(2);
      chk(checksum_error_flag, 1'b1);
    end
    @(posedge pclk);
    crc_good <= 1'b1;
    pulse(2);
    chk(checksum_error_flag, 1'b0);
    rd(ERRC_OFF, 32'h00020103, 1'b0);
    chk(bare_r, 32'h00000000);
    rd(ERRC_OFF, 32'h00000000, 1'b0);
    repeat (257) pulse(0);
    rd(ERRC_OFF, 32'h00000001, 1'b0);
    @(posedge pclk);
    crc_good <= 1'b0;
    pulse(2);
    pulse(5);
    rd(ERRC_OFF, 32'h00000000, 1'b0);
    $display("Test errors done");
  endtask
  task automatic t_phy;
    wr(PHYA_OFF, {6'h05, 2'b10, 8'h3C, 16'h0000}, 1'b0);
    rd(PHYA_OFF, {6'h05, 2'b10, 8'h3C, 16'h0001}, 1'b0);
    repeat (160) @(posedge pclk);
    chk(ulpi_data_oe, 1'b0);
    link_busy <= 1'b1;
    wr(ECTL_OFF, 32'h00000001, 1'b0);
    repeat (160) @(posedge pclk);
    chk(ulpi_data_oe, 1'b0);
    wr(PHYA_OFF, {6'h06, 2'b10, 8'h55, 16'h0000}, 1'b0);
    @(posedge pclk);
    link_busy <= 1'b0;
    wait_done();
    chk(stp_seen, 1);
    chk(u_phy.regs[5], 8'h3C);
    chk(u_phy.regs[6], 8'h00);
    rd(PHYA_OFF, {6'h05, 2'b10, 8'h3C, 16'h0000}, 1'b0);
    wr(PHYA_OFF, {6'h05, 2'b00, 8'h00, 16'h0000}, 1'b0);
    wait_done();
    chk(stp_seen, 1);
    rd(PHYA_OFF, {6'h05, 2'b00, 8'h3C, 16'h0000}, 1'b0);
    $display("Test link access done");
  endtask
  task automatic t_dma;
    wr(EPRDY_OFF, 32'h00000000, 1'b0);
    wr(DCTL_OFF, 32'h007F0003, 1'b0);
    chk(dma_dir, 1'b1);
    rd(DCTL_OFF, 32'h007F0003, 1'b0);
    rd(EPRDY_OFF, 32'h00000000, 1'b0);
    pulse(4);
    rd(EPRDY_OFF, 32'h007F0000, 1'b0);
    wr(DSR_OFF, 32'h00000005, 1'b1);
    repeat (3) @(posedge pclk);
    chk(rst_seen, 0);
    wr(DSR_OFF, DSR_KEY, 1'b0);
    repeat (3) @(posedge pclk);
    chk(rst_seen, 1);
    $display("Test dma done");
  endtask
  task automatic t_mode;
    wr(TSEL_OFF, 32'hA0000000, 1'b0);
    rd(TSEL_OFF, 32'hA0000000, 1'b0);
    chk({chirp_j, chirp_k, test_packet}, 3'b000);
    for (int m = 1; m < 5; m++) begin
      reset_dut();
      wr(TSEL_OFF, {m[2:0], 29'h0}, 1'b0);
      repeat (100) @(posedge pclk);
      #1;
      chk({chirp_j, chirp_k, test_packet}, {m == 1, m == 2, m == 4});
      wr(TSEL_OFF, 32'h00000000, 1'b0);
      rd(TSEL_OFF, {m[2:0], 29'h0}, 1'b0);
      @(posedge pclk);
      tok_ep <= 3'h0;
      tok_crc_ok <= 1'b1;
      pulse(3);
      chk(send_nak, m == 3);
      @(posedge pclk);
      tok_crc_ok <= 1'b0;
      pulse(3);
      chk(send_nak, 1'b0);
    end
    $display("Test modes done");
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence; all inputs start at a defined level.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {link_busy, usb_reset_det, stuff_err_evt, pid_evt, crc_evt, tok_evt, tok_in, tok_crc_ok, dma_done} = '0;
    crc_good = 1'b1;
    pid_byte = 8'h69;
    tok_ep = 3'h0;
    reset_dut();
    t_regs();
    t_ready();
    t_err();
    t_phy();
    t_dma();
    t_mode();
    report_and_stop();
  end
  // The whole run needs far less than this, so reaching it means a hang.
  initial begin
    #400000;
    n_fail++;
    report_and_stop();
  end
endmodule
